// File: nvm_params.svh
// Purpose: Constants of the two-wire memory slave front end
// Assumes: 200 MHz system clock
// Notes:   Definitions only
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// ==========================================================
// Array geometry
`define NVM_ADDR_W       15
`define NVM_DATA_W       8
`define NVM_ADDR_FIRST   15'h0000
`define NVM_ADDR_LAST    15'h7fff
`define NVM_ADDR_HI_W    7

// ==========================================================
// Slave address byte fields
`define NVM_SA_TYPE_MSB  7
`define NVM_SA_TYPE_LSB  4
`define NVM_SA_SEL_MSB   3
`define NVM_SA_SEL_LSB   1
`define NVM_SA_RW_BIT    0
`define NVM_SA_RW_READ   1'b1

// ==========================================================
// Bit counting and reset values
`define NVM_BIT_LAST     3'h7
`define NVM_BIT_RST      3'h0
`define NVM_BYTE_RST     8'h00

// ==========================================================
// Timing
`define NVM_SYS_CLK_NS   5
`define NVM_SCL_MIN_NS   1000
`define NVM_SCL_CYC      (`NVM_SCL_MIN_NS / `NVM_SYS_CLK_NS)
`define NVM_FIFO_DEPTH   4

`endif

// File: nvm_pkg.sv
// Purpose: Types of the two-wire memory slave front end
// Assumes: nvm_params.svh supplies the widths
// Notes:   One-hot protocol states
`default_nettype none
`include "nvm_params.svh"
package nvm_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_DEV  = 7'b0000010,
        ST_AHI  = 7'b0000100,
        ST_ALO  = 7'b0001000,
        ST_WDAT = 7'b0010000,
        ST_RDAT = 7'b0100000,
        ST_MACK = 7'b1000000
    } nvm_state_t;

    typedef enum logic [1:0] {
        BK_DEV  = 2'h0,
        BK_AHI  = 2'h1,
        BK_ALO  = 2'h2,
        BK_DATA = 2'h3
    } nvm_kind_t;

    typedef struct packed {
        logic [`NVM_ADDR_W-1:0] addr;
        logic [`NVM_DATA_W-1:0] data;
    } nvm_wreq_t;

endpackage
`default_nettype wire

// File: nvm_slave.sv
// Purpose: Two-wire serial slave for a 32768 x 8 byte memory
// Assumes: SCL, SDA, straps and lock are asynchronous pins
// Notes:   Writes pass a small FIFO before the array
`timescale 1ns/10ps
`default_nettype none
`include "nvm_params.svh"

// ==========================================================
// Write FIFO
module nvm_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    assign in_ready_o  = (count != (AW+1)'(D));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop) rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==========================================================
// Slave top
module nvm_slave
    import nvm_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'hc  // Arbitrary neutral value
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [2:0] device_select_straps_i,
    input  wire logic       array_lock_i
);
    localparam int AW = `NVM_ADDR_W;
    localparam int DW = `NVM_DATA_W;

    // ======================================================
    // Pin synchronisers
    logic [5:0] pin_m;  // {scl, sda, straps, lock}
    logic [5:0] pin_s;
    logic       scl_q, sda_q;
    logic [2:0] straps;
    logic       lock;
    logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

    // Pull-downs live in the pads; a float arrives here as low
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_m <= 6'h30;
            pin_s <= 6'h30;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            pin_m <= {scl_i, sda_i, device_select_straps_i, array_lock_i};
            pin_s <= pin_m;
            scl_q <= pin_s[5];
            sda_q <= pin_s[4];
        end
    end

    assign scl_s    = pin_s[5];
    assign sda_s    = pin_s[4];
    assign straps   = pin_s[3:1];
    assign lock     = pin_s[0];
    // 200 MHz sampling resolves SCL up to 1 MHz easily
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    // ======================================================
    // Protocol state
    nvm_state_t     state;
    nvm_kind_t      kind;
    logic [2:0]     bit_cnt;
    logic [AW-1:0]  addr;
    logic [DW-1:0]  shreg, rd_data, next_byte;
    logic           rw, in_ack, ack_on, ack_go, tx_done, rd_req;
    logic           byte_end, dev_hit;
    logic           w_valid, w_ready, m_valid, m_ready;
    nvm_wreq_t      w_req, m_req;
    logic [DW-1:0]  array [2**AW];

    assign next_byte = {shreg[DW-2:0], sda_s};
    assign byte_end  = scl_rise & ~in_ack & (bit_cnt == `NVM_BIT_LAST);
    assign dev_hit   =
        (next_byte[`NVM_SA_TYPE_MSB:`NVM_SA_TYPE_LSB] == DEV_TYPE) &&
        (next_byte[`NVM_SA_SEL_MSB:`NVM_SA_SEL_LSB] == straps);
    assign w_valid   = (state == ST_WDAT) & byte_end & ~lock;
    assign w_req     = '{addr: addr, data: next_byte};
    // Read fetch on a read slave-address hit or a master ack
    assign rd_req    = ((state == ST_DEV) & byte_end & dev_hit &
                        next_byte[`NVM_SA_RW_BIT]) |
                       ((state == ST_MACK) & scl_rise & ~sda_s);
    assign sda_o     = 1'b0;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state    <= ST_IDLE;
            kind     <= BK_DEV;
            bit_cnt  <= `NVM_BIT_RST;
            shreg    <= `NVM_BYTE_RST;
            addr     <= `NVM_ADDR_FIRST;
            rw       <= 1'b0;
            in_ack   <= 1'b0;
            ack_on   <= 1'b0;
            ack_go   <= 1'b0;
            tx_done  <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_c || stop_c) begin
            state    <= start_c ? ST_DEV : ST_IDLE;
            bit_cnt  <= `NVM_BIT_RST;
            in_ack   <= 1'b0;
            ack_on   <= 1'b0;
            tx_done  <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (in_ack) begin
            if (scl_fall && !ack_on) begin
                ack_on   <= 1'b1;
                sda_oe_o <= ack_go;
            end else if (scl_fall) begin
                in_ack  <= 1'b0;
                ack_on  <= 1'b0;
                bit_cnt <= `NVM_BIT_RST;
                if (!ack_go) begin
                    state    <= ST_IDLE;
                    sda_oe_o <= 1'b0;
                end else if (rw) begin
                    state    <= ST_RDAT;
                    shreg    <= rd_data;
                    sda_oe_o <= ~rd_data[DW-1];
                end else begin
                    sda_oe_o <= 1'b0;
                    unique case (kind)
                        BK_DEV:  state <= ST_AHI;
                        BK_AHI:  state <= ST_ALO;
                        BK_ALO:  state <= ST_WDAT;
                        BK_DATA: state <= ST_WDAT;
                    endcase
                end
            end
        end else begin
            unique case (state)
                ST_IDLE: sda_oe_o <= 1'b0;
                ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
                    if (scl_rise) begin
                        shreg   <= next_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (byte_end) begin
                        in_ack <= 1'b1;
                        ack_go <= 1'b1;
                        unique case (state)
                            ST_DEV: begin
                                kind   <= BK_DEV;
                                rw     <= next_byte[`NVM_SA_RW_BIT] ==
                                          `NVM_SA_RW_READ;
                                ack_go <= dev_hit;
                                if (!dev_hit) state <= ST_IDLE;
                            end
                            ST_AHI: begin
                                kind <= BK_AHI;
                                // Top received bit dropped
                                addr[AW-1:DW] <= next_byte[`NVM_ADDR_HI_W-1:0];
                            end
                            ST_ALO: begin
                                kind         <= BK_ALO;
                                addr[DW-1:0] <= next_byte;
                            end
                            default: begin
                                kind <= BK_DATA;
                                // Full FIFO refuses the byte with a nack unless lock is set
                                ack_go <= w_ready | lock;
                                if (w_ready || lock) begin
                                    addr <= addr + 15'h0001;
                                end
                            end
                        endcase
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `NVM_BIT_LAST) begin
                            tx_done <= 1'b1;
                            addr    <= addr + 15'h0001;
                        end
                    end else if (scl_fall && tx_done) begin
                        tx_done  <= 1'b0;
                        sda_oe_o <= 1'b0;
                        state    <= ST_MACK;
                    end else if (scl_fall) begin
                        shreg    <= {shreg[DW-2:0], 1'b0};
                        sda_oe_o <= ~shreg[DW-2];
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_s) begin
                        state <= ST_IDLE;
                    end else if (scl_rise) begin
                        in_ack <= 1'b1;
                        ack_on <= 1'b1;
                        ack_go <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Write path and array
    nvm_fifo #(
        .W ($bits(nvm_wreq_t)),
        .D (`NVM_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (w_valid),
        .in_ready_o  (w_ready),
        .in_data_i   (w_req),
        .out_valid_o (m_valid),
        .out_ready_i (m_ready),
        .out_data_o  (m_req)
    );

    // Single port: a read fetch stalls the drain
    assign m_ready = ~rd_req;

    always_ff @(posedge sys_clk_i) begin
        if (m_valid && m_ready) array[m_req.addr] <= m_req.data;
        if (rd_req) rd_data <= array[addr];
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_sda_low_only: assert property (sda_o == 1'b0)
        else $error("SDA driven high");
    a_launch_on_fall: assert property (
        $changed(sda_oe_o) |->
            $past(scl_fall) || $past(start_c) || $past(stop_c))
        else $error("SDA changed away from SCL fall");
    a_select_miss: assert property (
        (state == ST_DEV) && byte_end && !dev_hit |=> state == ST_IDLE)
        else $error("Unselected device kept the bus");
    a_lock_no_push: assert property ($rose(m_valid) |-> !$past(lock))
        else $error("Write queued while locked");
    a_locked_advance: assert property (
        (state == ST_WDAT) && byte_end && lock |=>
            addr == $past(addr) + 15'h0001)
        else $error("Locked write did not advance");
    a_addr_wrap: assert property (
        (state == ST_RDAT) && scl_rise && (bit_cnt == `NVM_BIT_LAST) &&
            (addr == `NVM_ADDR_LAST) |=> addr == `NVM_ADDR_FIRST)
        else $error("Address did not wrap");
    a_addr_high: assert property (
        (state == ST_AHI) && byte_end |=>
            addr[AW-1:DW] == `NVM_ADDR_HI_W'($past(next_byte)))
        else $error("High address byte wrong");
    a_commit_fast: assert property (
        w_valid && w_ready && !m_valid |-> ##[1:3] !m_valid)
        else $error("Write not committed promptly");
    a_nack_ends: assert property (
        (state == ST_MACK) && scl_rise && sda_s && !in_ack |=>
            state == ST_IDLE && !sda_oe_o)
        else $error("Read not ended on nack");
    a_start_abort: assert property (
        start_c |=> state == ST_DEV && !sda_oe_o && !in_ack)
        else $error("START did not abort");

    c_write_byte: cover property (w_valid && w_ready);
    c_read_nack:  cover property ((state == ST_MACK) && scl_rise && sda_s);
    c_miss:       cover property ((state == ST_DEV) && byte_end && !dev_hit);
    c_locked:     cover property ((state == ST_WDAT) && byte_end && lock);
endmodule
`default_nettype wire

// File: nvm_bus_master.sv
// Purpose: Behavioural two-wire bus master driving SCL and SDA
// Assumes: SDA has a pull-up, so a released line reads high
// Notes:   SCL rests high between frames; tasks called from the bench
`timescale 1ns/10ps
`default_nettype none
module nvm_bus_master (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    // ==========================================================
    // Bit timing, 125 ns SCL period
    localparam realtime HALF  = 62.5;
    localparam realtime SETUP = 30.0;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // ==========================================================
    // Frame conditions
    task automatic start_cond();
        if (scl_o === 1'b0) begin
            #(SETUP) sda_o = 1'b1;
            #(HALF - SETUP) scl_o = 1'b1;
            #(HALF);
        end
        sda_o = 1'b0;
        #(HALF) scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        #(SETUP) sda_o = 1'b0;
        #(HALF - SETUP) scl_o = 1'b1;
        #(HALF) sda_o = 1'b1;
        #(HALF);
    endtask

    // ==========================================================
    // Bits and bytes
    // Data moves only while SCL is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        #(SETUP) sda_o = b;
        #(HALF - SETUP) scl_o = 1'b1;
        #(HALF / 2) s = sda_i;
        #(HALF / 2) scl_o = 1'b0;
    endtask

    // MSB first; fewer than 8 bits leaves out the ack slot
    task automatic send_bits(input logic [7:0] d, input int n,
                             output logic ack_n);
        logic s;
        ack_n = 1'b1;
        for (int i = 0; i < n; i++) begin
            bit_io(d[7 - i], s);
        end
        if (n == 8) begin
            bit_io(1'b1, ack_n);
        end
    endtask

    // Ack every byte but the last
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s);
            d = {d[6:0], s};
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// File: nvm_slave_tb_top.sv
// Purpose: Self-checking bench for the two-wire memory slave
// Assumes: 200 MHz system clock; bus model makes a 125 ns SCL
// Notes:   Bench keeps its own copy of written bytes
`timescale 1ns/10ps
`default_nettype none
module nvm_slave_tb_top
    import nvm_pkg::*;
();
    localparam logic [3:0] DT = 4'h6; // Arbitrary device type value

    logic       sys_clk;
    logic       rst_n;
    logic       scl;
    logic       mst_sda;
    logic       sda_o;
    logic       sda_oe;
    logic       lock;
    logic [2:0] straps;
    wire logic  sda_bus;
    int         n_mismatch;
    int         num_checks;
    logic [7:0] exp_mem [0:32767];

    assign sda_bus = mst_sda & ~sda_oe;

    nvm_bus_master bus_u (.scl_o(scl), .sda_o(mst_sda), .sda_i(sda_bus));
    nvm_slave #(.DEV_TYPE(DT)) dut_u (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl),
        .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .device_select_straps_i(straps), .array_lock_i(lock));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [14:0] next_addr(input logic [14:0] a);
        return (a == 15'h7fff) ? 15'h0000 : a + 15'h0001;
    endfunction

    always @(posedge sys_clk) begin
        if (sda_oe === 1'b1) begin
            check("sda_o", {15'h0, sda_o}, 16'h0);
        end
    end

    always @(sda_oe) begin
        if (rst_n === 1'b1) begin
            check("oe_change_scl", {15'h0, scl}, 16'h0);
        end
    end

    // ==========================================================
    // Bus sequences
    task automatic set_pins(input logic [2:0] s, input logic l);
        @(posedge sys_clk);
        #1;
        straps = s;
        lock = l;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic hdr(input logic [2:0] sel, input logic rd,
                       input logic exp_n);
        logic ack_n;
        bus_u.send_bits({DT, sel, rd}, 8, ack_n);
        check("addr_ack_n", {15'h0, ack_n}, {15'h0, exp_n});
    endtask

    task automatic set_addr(input logic [15:0] a);
        logic ack_n;
        bus_u.start_cond();
        hdr(straps, 1'b0, 1'b0);
        bus_u.send_bits(a[15:8], 8, ack_n);
        check("hi_ack_n", {15'h0, ack_n}, 16'h0);
        bus_u.send_bits(a[7:0], 8, ack_n);
        check("lo_ack_n", {15'h0, ack_n}, 16'h0);
    endtask

    task automatic wr_bytes(input logic [15:0] a, input int n);
        logic [14:0] p;
        logic [7:0]  d;
        logic        ack_n;
        p = a[14:0];
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            bus_u.send_bits(d, 8, ack_n);
            check("data_ack_n", {15'h0, ack_n}, 16'h0);
            if (lock === 1'b0) begin
                exp_mem[p] = d;
            end
            p = next_addr(p);
        end
        bus_u.stop_cond();
    endtask

    task automatic rd_bytes(input logic [15:0] a, input logic rnd,
                            input int n);
        logic [14:0] p;
        logic [7:0]  d;
        p = a[14:0];
        if (rnd) begin
            set_addr(a);
        end
        bus_u.start_cond();
        hdr(straps, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            bus_u.recv_byte(i == n - 1, d);
            check("rd_data", {8'h0, d}, {8'h0, exp_mem[p]});
            p = next_addr(p);
        end
        bus_u.stop_cond();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] a;
        logic        ack_n;
        int          n;
        n_mismatch = 0;
        num_checks = 0;
        rst_n = 1'b0;
        straps = 3'h0;
        lock = 1'b0;
        void'($urandom(32'ha17d));
        repeat (10) @(posedge sys_clk);
        #1;
        check("oe_in_reset", {15'h0, sda_oe}, 16'h0);
        rst_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        for (int s = 0; s < 8; s++) begin
            set_pins(3'(s), 1'b0);
            bus_u.start_cond();
            hdr(3'(s), 1'b0, 1'b0);
            bus_u.stop_cond();
            bus_u.start_cond();
            hdr(3'(s) ^ 3'h5, 1'b0, 1'b1);
            bus_u.stop_cond();
            bus_u.start_cond();
            bus_u.send_bits({~DT, 3'(s), 1'b0}, 8, ack_n);
            check("type_ack_n", {15'h0, ack_n}, 16'h1);
            bus_u.stop_cond();
        end
        wr_bytes(16'hfffe, 4);
        rd_bytes(16'h7ffe, 1'b1, 4);
        wr_bytes(16'h1234, 4);
        rd_bytes(16'h1234, 1'b1, 1);
        rd_bytes(16'h1235, 1'b0, 3);
        set_pins(straps, 1'b1);
        wr_bytes(16'h1234, 3);
        set_pins(straps, 1'b0);
        rd_bytes(16'h1237, 1'b0, 1);
        rd_bytes(16'h1234, 1'b1, 3);
        set_addr(16'h1234);
        bus_u.send_bits(8'($urandom), 5, ack_n);
        bus_u.stop_cond();
        set_addr(16'h1235);
        bus_u.send_bits(8'($urandom), 3, ack_n);
        rd_bytes(16'h1235, 1'b0, 2);
        rd_bytes(16'h1234, 1'b1, 1);
        for (int k = 0; k < 4; k++) begin
            a = 16'($urandom);
            n = 1 + int'($urandom % 6);
            wr_bytes(a, n);
            rd_bytes({1'b0, a[14:0]}, 1'b1, n);
        end
        final_report();
    end

    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
